// *** shared/bss_consts.svh ***
// Constants for the block-size and sleep command handler.
// Assumes a single 125 MHz clock and a command strobe from the link layer.
`ifndef BSS_CONSTS_SVH
`define BSS_CONSTS_SVH
`define BSS_OP_SET_BLOCK   8'hc6
`define BSS_OP_SLEEP_A     8'he6
`define BSS_OP_SLEEP_B     8'h99
`define BSS_BLOCK_DEFAULT  5'h10
`define BSS_STATUS_RESET   8'h40
`define BSS_ERR_ABORT_BIT  2
`define BSS_ST_BUSY_BIT    7
`define BSS_ST_READY_BIT   6
`define BSS_ST_SEEK_BIT    4
`define BSS_ST_ERROR_BIT   0
`endif

// *** shared/bss_pkg.sv ***
// Types for the block-size and sleep command handler.
// Assumes the constants header is included alongside.
package bss_pkg;
  typedef enum logic [2:0] {
    BSS_IDLE, BSS_FLUSH, BSS_SPIN, BSS_SLEEP
  } bss_state_t;
endpackage : bss_pkg

// *** testbench/bss_drive_model.sv ***
// Drive-side model: write cache and spindle answering flush and spin-down.
// Assumes the same clock and reset as the command handler.
`timescale 1ns/1ns
module bss_drive_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic load_pending,
  input  wire logic cache_flush_req,
  input  wire logic spin_down_req,
  output logic      cache_write_pending,
  output logic      spun_down,
  output logic      spin_down_done
);
  logic [1:0] flush_cnt_reg;
  logic [1:0] spin_cnt_reg;
  always_ff @(posedge clk) begin
    spin_down_done <= 1'b0;
    if (rst) begin
      cache_write_pending <= 1'b0;
      spun_down           <= 1'b0;
      flush_cnt_reg       <= 2'h0;
      spin_cnt_reg        <= 2'h0;
    end else begin
      if (load_pending) begin
        cache_write_pending <= 1'b1;
      end else if (cache_flush_req && cache_write_pending) begin
        // Flush takes a few cycles so the handler must really wait
        flush_cnt_reg <= flush_cnt_reg + 2'h1;
        if (flush_cnt_reg == 2'h2) begin
          cache_write_pending <= 1'b0;
          flush_cnt_reg       <= 2'h0;
        end
      end
      if (spin_down_req && !spun_down) begin
        spin_cnt_reg <= spin_cnt_reg + 2'h1;
        if (spin_cnt_reg == 2'h2) begin
          spun_down      <= 1'b1;
          spin_down_done <= 1'b1;
          spin_cnt_reg   <= 2'h0;
        end
      end
    end
  end
endmodule : bss_drive_model

// *** testbench/testbench.sv ***
// Self-checking bench for the block-size and sleep command handler.
// Assumes the drive model answers flush and spin-down requests.
`timescale 1ns/1ns
`include "bss_consts.svh"
module testbench;
  logic clk = 0, rst = 1, cmd_valid = 0, soft_reset = 0, link_reset = 0, load_pending = 0;
  logic [7:0] cmd_opcode = 8'h00, cmd_sector_count = 8'h00, err, st;
  logic [4:0] block_size;
  logic cmd_done, multi_enable, cache_flush_req, spin_down_req, interface_active, sleeping;
  logic cache_write_pending, spun_down, spin_down_done, got, saw_spin;
  logic [7:0] sizes [8] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h03, 8'h20};
  logic [4:0] exp_size;
  integer error_cnt = 0, samples_checked = 0, i;
  bss_cmd bss_cmd_i (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
    .cmd_sector_count(cmd_sector_count), .soft_reset(soft_reset), .link_reset(link_reset),
    .cache_write_pending(cache_write_pending), .spun_down(spun_down),
    .spin_down_done(spin_down_done), .cmd_done(cmd_done), .command_error_report(err),
    .drive_status_flags(st), .block_size(block_size), .multi_enable(multi_enable),
    .cache_flush_req(cache_flush_req), .spin_down_req(spin_down_req),
    .interface_active(interface_active), .sleeping(sleeping));
  bss_drive_model bss_drive_model_i (.clk(clk), .rst(rst), .load_pending(load_pending),
    .cache_flush_req(cache_flush_req), .spin_down_req(spin_down_req),
    .cache_write_pending(cache_write_pending), .spun_down(spun_down),
    .spin_down_done(spin_down_done));
  initial forever #4 clk = ~clk;
  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Issue one command; ignored ones simply time out with got low
  task cmd(input logic [7:0] op, input logic [7:0] cnt);
    integer n;
    @(negedge clk); cmd_opcode = op; cmd_sector_count = cnt; cmd_valid = 1;
    @(negedge clk); cmd_valid = 0; got = cmd_done; saw_spin = spin_down_req;
    for (n = 0; n < 40 && got !== 1'b1; n++) begin
      @(negedge clk); got = cmd_done; saw_spin |= spin_down_req;
      chk("spin before flush", {7'h0, spin_down_req & cache_write_pending}, 8'h00);
    end
  endtask : cmd
  task test_done;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  initial begin
    #100000; error_cnt++; test_done;
  end
  initial begin
    repeat (2) @(negedge clk); rst = 0;
    chk("default size", {3'h0, block_size}, 8'h10);
    chk("default multi", {7'h0, multi_enable}, 8'h01);
    exp_size = 5'h10;
    for (i = 0; i < 8; i++) begin
      cmd(`BSS_OP_SET_BLOCK, sizes[i]);
      if (i < 6) exp_size = sizes[i][4:0];
      chk("set done", {7'h0, got}, 8'h01);
      chk("size", {3'h0, block_size}, {3'h0, exp_size});
      chk("multi", {7'h0, multi_enable}, (i > 0 && i < 6) ? 8'h01 : 8'h00);
      chk("error reg", err, (i < 6) ? 8'h00 : 8'h04);
      chk("status err", {6'h0, st[7], st[0]}, (i < 6) ? 8'h00 : 8'h01);
      chk("status", st, (i < 6) ? 8'h50 : 8'h51);
    end
    cmd(8'he7, 8'h00);
    chk("odd opcode", {6'h0, got, sleeping}, 8'h00);
    @(negedge clk); load_pending = 1; @(negedge clk); load_pending = 0;
    cmd(`BSS_OP_SLEEP_A, 8'h00);
    chk("sleep", {4'h0, got, sleeping, interface_active, saw_spin}, 8'h0d);
    chk("sleep status", st, 8'h40);
    chk("reqs idle", {6'h0, cache_flush_req, spin_down_req}, 8'h00);
    cmd(`BSS_OP_SET_BLOCK, 8'h02);
    chk("asleep cmd", {2'h0, got, block_size}, {3'h0, exp_size});
    @(negedge clk); soft_reset = 1; @(negedge clk); soft_reset = 0; @(negedge clk);
    chk("soft wake", {6'h0, interface_active, sleeping}, 8'h02);
    chk("soft wake status", st, 8'h40);
    cmd(`BSS_OP_SLEEP_B, 8'h00);
    chk("stopped sleep", {5'h0, got, sleeping, saw_spin}, 8'h06);
    @(negedge clk); link_reset = 1; @(negedge clk); link_reset = 0; @(negedge clk);
    chk("link wake", {6'h0, interface_active, sleeping}, 8'h02);
    chk("link wake status", st, 8'h40);
    test_done;
  end
endmodule : testbench

// *** verilog/bss_cmd.sv ***
// Block-size and sleep command handler.
// Assumes cmd_valid is a one-cycle strobe from logic on clk, and that
// flush, spin-down and spindle status come from same-clock drive logic.
`timescale 1ns/1ns
`include "bss_consts.svh"
module bss_cmd
  import bss_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_opcode,
  input  wire logic [7:0] cmd_sector_count,
  input  wire logic       soft_reset,
  input  wire logic       link_reset,
  input  wire logic       cache_write_pending,
  input  wire logic       spun_down,
  input  wire logic       spin_down_done,
  output logic            cmd_done,
  output logic [7:0]      command_error_report,
  output logic [7:0]      drive_status_flags,
  output logic [4:0]      block_size,
  output logic            multi_enable,
  output logic            cache_flush_req,
  output logic            spin_down_req,
  output logic            interface_active,
  output logic            sleeping
);
  typedef struct packed {
    bss_state_t st;
    logic       done;
    logic [7:0] err;
    logic [7:0] stat;
    logic [4:0] size;
    logic       multi;
    logic       flush;
    logic       spin;
    logic       if_on;
    logic       asleep;
  } bss_regs_t;

  bss_regs_t  s_reg;
  bss_regs_t  s_next;
  logic       size_ok;
  logic       size_en;

  bss_size_check u_check (
    .count  (cmd_sector_count),
    .valid  (size_ok),
    .enable (size_en)
  );

  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    unique case (s_reg.st)
      BSS_IDLE: begin
        if (cmd_valid) begin
          s_next.err  = 8'h00;
          s_next.stat = 8'h00;
          s_next.stat[`BSS_ST_READY_BIT] = 1'b1;
          s_next.stat[`BSS_ST_SEEK_BIT]  = ~spun_down;
          if (cmd_opcode == `BSS_OP_SET_BLOCK) begin
            s_next.done = 1'b1;
            if (size_ok) begin
              s_next.size  = cmd_sector_count[4:0];
              s_next.multi = size_en;
            end else begin
              s_next.multi = 1'b0;
              s_next.err[`BSS_ERR_ABORT_BIT] = 1'b1;
              s_next.stat[`BSS_ST_ERROR_BIT] = 1'b1;
            end
          end else if (cmd_opcode == `BSS_OP_SLEEP_A ||
                       cmd_opcode == `BSS_OP_SLEEP_B) begin
            s_next.stat[`BSS_ST_BUSY_BIT] = 1'b1;
            s_next.flush = 1'b1;
            s_next.st    = BSS_FLUSH;
          end
        end
      end
      BSS_FLUSH: begin
        if (!cache_write_pending) begin
          s_next.flush = 1'b0;
          if (spun_down) begin
            s_next.st = BSS_SLEEP;
          end else begin
            s_next.spin = 1'b1;
            s_next.st   = BSS_SPIN;
          end
        end
      end
      BSS_SPIN: begin
        if (spin_down_done) begin
          s_next.spin = 1'b0;
          s_next.st   = BSS_SLEEP;
        end
      end
      BSS_SLEEP: begin
        if (s_reg.if_on) begin
          s_next.if_on  = 1'b0;
          s_next.asleep = 1'b1;
          s_next.done   = 1'b1;
          s_next.stat[`BSS_ST_BUSY_BIT] = 1'b0;
          s_next.stat[`BSS_ST_SEEK_BIT] = 1'b0;
        end
        if (soft_reset || link_reset) begin
          s_next.if_on  = 1'b1;
          s_next.asleep = 1'b0;
          s_next.st     = BSS_IDLE;
          s_next.stat  = 8'h00;
          s_next.stat[`BSS_ST_READY_BIT] = 1'b1;
        end
      end
      default: s_next.st = BSS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg       <= '0;
      s_reg.st    <= BSS_IDLE;
      s_reg.size  <= `BSS_BLOCK_DEFAULT;
      s_reg.multi <= 1'b1;
      s_reg.if_on <= 1'b1;
      s_reg.stat  <= `BSS_STATUS_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  always_comb begin
    cmd_done             = s_reg.done;
    command_error_report = s_reg.err;
    drive_status_flags   = s_reg.stat;
    block_size           = s_reg.size;
    multi_enable         = s_reg.multi;
    cache_flush_req      = s_reg.flush;
    spin_down_req        = s_reg.spin;
    interface_active     = s_reg.if_on;
    sleeping             = s_reg.asleep;
  end

  inval_abort_a: assert property (@(posedge clk) disable iff (rst)
    cmd_valid && s_reg.st == BSS_IDLE && cmd_opcode == 8'hc6 && !size_ok
    |=> cmd_done && !multi_enable && command_error_report == 8'h04)
    else $error("invalid size not aborted");

  zero_size_a: assert property (@(posedge clk) disable iff (rst)
    cmd_valid && s_reg.st == BSS_IDLE && cmd_opcode == 8'hc6 &&
    cmd_sector_count == 8'h00 |=> !multi_enable && command_error_report == 8'h00)
    else $error("zero size mishandled");

  size_store_a: assert property (@(posedge clk) disable iff (rst)
    cmd_valid && s_reg.st == BSS_IDLE && cmd_opcode == 8'hc6 && size_en
    |=> multi_enable && block_size == $past(cmd_sector_count[4:0]))
    else $error("block size not stored");

  size_done_a: assert property (@(posedge clk) disable iff (rst)
    cmd_valid && s_reg.st == BSS_IDLE && cmd_opcode == 8'hc6
    |=> cmd_done)
    else $error("block-size command not completed");

  default_size_a: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> block_size == `BSS_BLOCK_DEFAULT && multi_enable)
    else $error("power-up block size wrong");

  sleep_cause_a: assert property (@(posedge clk) disable iff (rst)
    s_reg.st == BSS_IDLE && !(cmd_valid && (cmd_opcode == 8'he6 ||
    cmd_opcode == 8'h99)) |=> s_reg.st == BSS_IDLE)
    else $error("sleep entered without command");

  flush_first_a: assert property (@(posedge clk) disable iff (rst)
    spin_down_req |-> !cache_flush_req) else $error("spin during flush");

  flush_order_a: assert property (@(posedge clk) disable iff (rst)
    $rose(spin_down_req) |-> $past(cache_write_pending) == 1'b0)
    else $error("spin started with writes pending");

  spin_then_idle_a: assert property (@(posedge clk) disable iff (rst)
    s_reg.st == BSS_SPIN && spin_down_done |=> ##1 !interface_active)
    else $error("interface not idled");

  spin_hold_a: assert property (@(posedge clk) disable iff (rst)
    spin_down_req && !spin_down_done |=> spin_down_req)
    else $error("spin request dropped early");

  sleep_done_a: assert property (@(posedge clk) disable iff (rst)
    $fell(interface_active) |-> cmd_done && sleeping && !drive_status_flags[7])
    else $error("sleep entry incomplete");

  wake_reset_a: assert property (@(posedge clk) disable iff (rst)
    sleeping && !soft_reset && !link_reset |=> !interface_active)
    else $error("woke without reset");

  wake_ready_a: assert property (@(posedge clk) disable iff (rst)
    $rose(interface_active) |-> drive_status_flags == 8'h40 && !sleeping)
    else $error("wake status wrong");

  skip_spin_a: assert property (@(posedge clk) disable iff (rst)
    s_reg.st == BSS_FLUSH && !cache_write_pending && spun_down
    |=> !spin_down_req ##1 sleeping) else $error("spin not skipped");

  abort_stat_a: assert property (@(posedge clk) disable iff (rst)
    command_error_report[2] |-> drive_status_flags[0] && !drive_status_flags[7])
    else $error("abort status wrong");

  abort_only_a: assert property (@(posedge clk) disable iff (rst)
    command_error_report != 8'h00 |-> command_error_report == 8'h04)
    else $error("unexpected error flag");
endmodule : bss_cmd

// *** verilog/bss_size_check.sv ***
// Block-size validator.
// Assumes a plain 8-bit sector count from the command block.
`timescale 1ns/1ns
module bss_size_check
  import bss_pkg::*;
(
  input  wire logic [7:0] count,
  output logic            valid,
  output logic            enable
);
  always_comb begin
    valid  = (count == 8'h00) || (count == 8'h01) || (count == 8'h02) ||
             (count == 8'h04) || (count == 8'h08) || (count == 8'h10);
    enable = valid && (count != 8'h00);
  end
endmodule : bss_size_check
